// ==== include/csq_pkg.sv ====
// Constants and types shared by the course program branch sequencer.
package csq_pkg;
    // Widths and depths.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int LINE_W = 4;
    localparam int POS_W  = 6;
    localparam int LINES  = 16;
    localparam int N_IN   = 3;
    // Synchronised input slots: branch input a, branch input b, stop (active low).
    localparam int IN_A    = 0;
    localparam int IN_B    = 1;
    localparam int IN_STOP = 2;
    localparam logic [N_IN-1:0] SYNC_RST = 3'h4;
    // Register offsets.
    localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_PROG     = 8'h40;
    localparam logic [ADDR_W-1:0] OFS_PROG_END = 8'h80;
    localparam int PROG_IDX_LSB = 2;
    // Control register fields.
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_HALT_BIT  = 1;
    localparam int CTRL_LINE_LSB  = 4;
    // Status register fields.
    localparam int ST_RUN_BIT    = 0;
    localparam int ST_STOP_BIT   = 1;
    localparam int ST_MOVING_BIT = 2;
    localparam int ST_LINE_LSB   = 4;
    localparam int ST_POS_LSB    = 8;
    localparam int ST_IN_A_BIT   = 16;
    localparam int ST_IN_B_BIT   = 17;
    localparam int ST_OUT_LSB    = 18;
    // Program line word fields.
    localparam int CMD_LSB       = 0;
    localparam int EVAL_A_BIT    = 2;
    localparam int EVAL_B_BIT    = 3;
    localparam int EVAL_STOP_BIT = 4;
    localparam int MODE_A_LSB    = 5;
    localparam int MODE_B_LSB    = 7;
    localparam int LVL_IMM_BIT   = 9;
    localparam int OUT_A_LSB     = 10;
    localparam int BRANCH_INPUT_A_LSB     = 14;
    localparam int BRANCH_INPUT_B_LSB     = 18;
    localparam int POS_LSB       = 22;
    // Reset values.
    localparam logic [LINE_W-1:0] RST_LINE = 4'h0;
    localparam logic [POS_W-1:0]  RST_POS  = 6'h00;
    localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {CMD_MOVE, CMD_BRANCH, CMD_LEVEL, CMD_END} csq_cmd_t;
    typedef enum logic [1:0] {BM_IGNORE, BM_IMMEDIATE, BM_COMPLETE} csq_bmode_t;
    typedef enum logic [1:0] {OM_OFF, OM_ON, OM_TARGET, OM_REMAIN} csq_omode_t;
    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC} csq_state_t;
endpackage

// ==== include/csq_core_if.sv ====
// Bundle between the sequencer, its input synchroniser and its program memory.
`timescale 1ns/1ps
`default_nettype none
interface csq_core_if;
    import csq_pkg::*;
    logic [N_IN-1:0]   raw;
    logic [N_IN-1:0]   lvl;
    logic [N_IN-1:0]   rise;
    logic              wr_en;
    logic [LINE_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic              rd_en;
    logic [LINE_W-1:0] rd_addr;
    logic [DATA_W-1:0] rd_data;
    modport seq  (output raw, wr_en, wr_addr, wr_data, rd_en, rd_addr, input lvl, rise, rd_data);
    modport sync (input raw, output lvl, rise);
    modport mem  (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface // csq_core_if
`default_nettype wire

// ==== design/csq_in_sync.sv ====
// Two-stage synchroniser and rising edge detector for the program inputs.
`timescale 1ns/1ps
`default_nettype none
module csq_in_sync (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rstn_i,
    // Synchroniser side of the core bundle
    csq_core_if.sync  sif
);
    import csq_pkg::*;

    for (genvar gi = 0; gi < N_IN; gi++) begin : g_in
        logic meta, stab, prev;
        logic next_meta, next_stab, next_prev;
        always_comb begin
            next_meta = sif.raw[gi];
            next_stab = meta;
            next_prev = stab;
        end
        always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                meta <= SYNC_RST[gi];
                stab <= SYNC_RST[gi];
                prev <= SYNC_RST[gi];
            end else begin
                meta <= next_meta;
                stab <= next_stab;
                prev <= next_prev;
            end
        end
        assign sif.lvl[gi]  = stab;
        assign sif.rise[gi] = stab & ~prev;
    end
endmodule // csq_in_sync
`default_nettype wire

// ==== design/csq_prog_mem.sv ====
// Program line store with a registered read port.
`timescale 1ns/1ps
`default_nettype none
module csq_prog_mem (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rstn_i,
    // Memory side of the core bundle
    csq_core_if.mem   mif
);
    import csq_pkg::*;

    logic [DATA_W-1:0] store [LINES];
    logic [DATA_W-1:0] rd_q;
    logic [DATA_W-1:0] next_rd;

    always_ff @(posedge clk_i) begin
        if (mif.wr_en) begin
            store[mif.wr_addr] <= mif.wr_data;
        end
    end

    always_comb begin
        next_rd = mif.rd_en ? store[mif.rd_addr] : rd_q;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_q <= RST_WORD;
        end else begin
            rd_q <= next_rd;
        end
    end

    assign mif.rd_data = rd_q;
endmodule // csq_prog_mem
`default_nettype wire

// ==== design/csq_sequencer.sv ====
// Course program sequencer: line branches on two branch inputs and level tests on input a.
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Branch line, rising edge on input a continues at next line one.
// - Branch line, rising edge on input b continues at next line two.
// - Branch line waits in place while no usable edge has been seen.
// - Branch line with no input evaluated goes on to next line one.
// - Immediate mode acts on an edge while the positioning run still moves.
// - With both evaluated inputs usable, the input whose edge came first wins.
// - A move line starts a run and goes on without waiting for it.
// - Level test takes next line one while input a is high.
// - Level test takes next line two while input a is low.
// - Level test with equal destinations is an unconditional jump.
// - Immediate level test samples input a in the step's first cycle.
// - Level test either waits for the run to finish or evaluates at once.
// - Status shows program running and halted by the stop input.
// - Status shows line, last position, both inputs and both outputs.
// - Ignore mode drops edges that arrive while a run is in progress.
// - Complete-first mode waits for the run, then uses edges since its start.
// - Active stop halts the run and holds the line; edges are still caught.
// - On and off outputs act at once; target outputs when the run starts.
module csq_sequencer (
    // Clock and reset
    input  wire logic                        CLK_I,
    input  wire logic                        RSTN_I,
    // Register port
    input  wire logic [csq_pkg::ADDR_W-1:0]  ADDR_I,
    input  wire logic [csq_pkg::DATA_W-1:0]  WDATA_I,
    input  wire logic                        WR_I,
    input  wire logic                        RD_I,
    output logic      [csq_pkg::DATA_W-1:0]  RDATA_O,
    // Branch and stop inputs
    input  wire logic                        BRANCH_INPUT_A_I,
    input  wire logic                        BRANCH_INPUT_B_I,
    input  wire logic                        STOP_N_I,
    // Positioning engine
    input  wire logic                        TARGET_REACHED_I,
    input  wire logic                        REMAIN_DIST_I,
    output logic                             POS_START_O,
    output logic      [csq_pkg::POS_W-1:0]   POS_SET_O,
    output logic                             POS_HALT_O,
    // Program outputs
    output logic                             PROGRAM_OUTPUT_A_O,
    output logic                             PROGRAM_OUTPUT_B_O
);
    import csq_pkg::*;

    csq_core_if core ();

    csq_in_sync u_sync (
        .clk_i  (CLK_I),
        .rstn_i (RSTN_I),
        .sif    (core.sync)
    );

    csq_prog_mem u_mem (
        .clk_i  (CLK_I),
        .rstn_i (RSTN_I),
        .mif    (core.mem)
    );

    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    // Fields of the line held in the memory read register.
    logic [DATA_W-1:0] word;
    csq_cmd_t          cmd;
    csq_bmode_t        mode_a, mode_b;
    logic              eval_a, eval_b, eval_stop, lvl_imm;
    logic [LINE_W-1:0] branch_input_a, branch_input_b;
    logic [POS_W-1:0]  pos_fld;

    assign word      = core.rd_data;
    assign cmd       = csq_cmd_t'(word[CMD_LSB +: 2]);
    assign mode_a    = csq_bmode_t'(word[MODE_A_LSB +: 2]);
    assign mode_b    = csq_bmode_t'(word[MODE_B_LSB +: 2]);
    assign eval_a    = word[EVAL_A_BIT];
    assign eval_b    = word[EVAL_B_BIT];
    assign eval_stop = word[EVAL_STOP_BIT];
    assign lvl_imm   = word[LVL_IMM_BIT];
    assign branch_input_a     = word[BRANCH_INPUT_A_LSB +: LINE_W];
    assign branch_input_b     = word[BRANCH_INPUT_B_LSB +: LINE_W];
    assign pos_fld   = word[POS_LSB +: POS_W];

    assign core.raw = {STOP_N_I, BRANCH_INPUT_B_I, BRANCH_INPUT_A_I};

    logic in_a, in_b, rise_a, rise_b, stop_act, hold;
    assign in_a     = core.lvl[IN_A];
    assign in_b     = core.lvl[IN_B];
    assign rise_a   = core.rise[IN_A];
    assign rise_b   = core.rise[IN_B];
    assign stop_act = ~core.lvl[IN_STOP];
    assign hold     = eval_stop & stop_act;

    // Register port decode.
    logic ctrl_wr, start_req, halt_req;
    always_comb begin
        ctrl_wr       = 1'b0;
        core.wr_en    = 1'b0;
        core.wr_addr  = ADDR_I[PROG_IDX_LSB +: LINE_W];
        core.wr_data  = WDATA_I;
        if (WR_I && ADDR_I == OFS_CTRL) begin
            ctrl_wr = 1'b1;
        end else if (WR_I && ADDR_I >= OFS_PROG && ADDR_I < OFS_PROG_END && ADDR_I[1:0] == 2'h0) begin
            core.wr_en = 1'b1;
        end
        start_req = ctrl_wr & WDATA_I[CTRL_START_BIT];
        halt_req  = ctrl_wr & WDATA_I[CTRL_HALT_BIT];
    end

    // Sequencer state.
    csq_state_t        state, next_state;
    logic [LINE_W-1:0] line, next_line, dest;
    logic [POS_W-1:0]  pos, next_pos;
    logic              running, next_running;
    logic              first, next_first;
    logic              lvl_cap, next_lvl_cap;
    logic              start, next_start;
    logic              go, consume;
    // Edge latches and run tracking.
    logic              lat_a, lat_b, first_b, run_active, tr_prev;
    logic              next_lat_a, next_lat_b, next_first_b, next_run_active;
    logic              cap_a, cap_b, tr_rise, go_a, go_b, lvl;

    assign tr_rise = TARGET_REACHED_I & ~tr_prev;
    assign go_a    = eval_a & lat_a & (mode_a != BM_COMPLETE | ~run_active);
    assign go_b    = eval_b & lat_b & (mode_b != BM_COMPLETE | ~run_active);
    assign lvl     = (lvl_imm && first) ? in_a : (lvl_imm ? lvl_cap : in_a);

    always_comb begin
        next_state   = state;
        next_line    = line;
        next_pos     = pos;
        next_running = running;
        next_first   = 1'b0;
        next_lvl_cap = lvl_cap;
        next_start   = 1'b0;
        go           = 1'b0;
        dest         = branch_input_a;
        consume      = 1'b0;
        core.rd_en   = 1'b0;
        core.rd_addr = line;
        if (halt_req) begin
            next_state   = ST_IDLE;
            next_running = 1'b0;
        end else if (start_req) begin
            next_state   = ST_FETCH;
            next_line    = WDATA_I[CTRL_LINE_LSB +: LINE_W];
            next_running = 1'b1;
            consume      = 1'b1;
        end else begin
            case (state)
                ST_IDLE: begin
                    next_running = 1'b0;
                end
                ST_FETCH: begin
                    core.rd_en = 1'b1;
                    next_state = ST_EXEC;
                    next_first = 1'b1;
                end
                ST_EXEC: begin
                    if (first) begin
                        next_lvl_cap = in_a;
                    end
                    if (!hold) begin
                        case (cmd)
                            CMD_MOVE: begin
                                next_start = 1'b1;
                                next_pos   = pos_fld;
                                go         = 1'b1;
                            end
                            CMD_BRANCH: begin
                                if (!eval_a && !eval_b) begin
                                    go = 1'b1;
                                end else if (go_a && go_b) begin
                                    go   = 1'b1;
                                    dest = first_b ? branch_input_b : branch_input_a;
                                end else if (go_a) begin
                                    go = 1'b1;
                                end else if (go_b) begin
                                    go   = 1'b1;
                                    dest = branch_input_b;
                                end
                            end
                            CMD_LEVEL: begin
                                if (lvl_imm || !run_active) begin
                                    go   = 1'b1;
                                    dest = lvl ? branch_input_a : branch_input_b;
                                end
                            end
                            default: begin
                                next_state   = ST_IDLE;
                                next_running = 1'b0;
                            end
                        endcase
                    end
                    if (go) begin
                        next_state = ST_FETCH;
                        next_line  = dest;
                        consume    = 1'b1;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state   <= ST_IDLE;
            line    <= RST_LINE;
            pos     <= RST_POS;
            running <= 1'b0;
            first   <= 1'b0;
            lvl_cap <= 1'b0;
            start   <= 1'b0;
        end else begin
            state   <= next_state;
            line    <= next_line;
            pos     <= next_pos;
            running <= next_running;
            first   <= next_first;
            lvl_cap <= next_lvl_cap;
            start   <= next_start;
        end
    end

    // A new edge in the cycle that consumes the latches survives them.
    always_comb begin
        cap_a           = rise_a & ~(mode_a == BM_IGNORE & run_active);
        cap_b           = rise_b & ~(mode_b == BM_IGNORE & run_active);
        next_lat_a      = cap_a | (lat_a & ~consume);
        next_lat_b      = cap_b | (lat_b & ~consume);
        next_first_b    = ((lat_a | lat_b) & ~consume) ? first_b : (cap_b & ~cap_a);
        next_run_active = next_start | (run_active & ~tr_rise);
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            lat_a      <= 1'b0;
            lat_b      <= 1'b0;
            first_b    <= 1'b0;
            run_active <= 1'b0;
            tr_prev    <= 1'b0;
        end else begin
            lat_a      <= next_lat_a;
            lat_b      <= next_lat_b;
            first_b    <= next_first_b;
            run_active <= next_run_active;
            tr_prev    <= TARGET_REACHED_I;
        end
    end

    // Program outputs; the stop input leaves them alone.
    logic [1:0] out_lvl;
    for (genvar gi = 0; gi < 2; gi++) begin : g_out
        csq_omode_t fld, omode, next_omode;
        logic       out_q, next_out;
        assign fld = csq_omode_t'(word[OUT_A_LSB + 2 * gi +: 2]);
        always_comb begin
            next_omode = omode;
            if (state == ST_EXEC && first && (fld == OM_ON || fld == OM_OFF)) begin
                next_omode = fld;
            end else if (next_start && (fld == OM_TARGET || fld == OM_REMAIN)) begin
                next_omode = fld;
            end
            case (next_omode)
                OM_ON:     next_out = 1'b1;
                OM_TARGET: next_out = TARGET_REACHED_I;
                OM_REMAIN: next_out = REMAIN_DIST_I;
                default:   next_out = 1'b0;
            endcase
        end
        always_ff @(posedge CLK_I or negedge RSTN_I) begin
            if (!RSTN_I) begin
                omode <= OM_OFF;
                out_q <= 1'b0;
            end else begin
                omode <= next_omode;
                out_q <= next_out;
            end
        end
        assign out_lvl[gi] = out_q;
    end

    // Halt request to the engine and the read path.
    logic              halt, next_halt;
    logic [DATA_W-1:0] status, rdata, next_rdata;
    always_comb begin
        next_halt = running & hold & (state == ST_EXEC);
        status = '0;
        status[ST_RUN_BIT]              = running;
        status[ST_STOP_BIT]             = halt;
        status[ST_MOVING_BIT]           = run_active;
        status[ST_LINE_LSB +: LINE_W]   = line;
        status[ST_POS_LSB +: POS_W]     = pos;
        status[ST_IN_A_BIT]             = in_a;
        status[ST_IN_B_BIT]             = in_b;
        status[ST_OUT_LSB +: 2]         = out_lvl;
        if (RD_I && ADDR_I == OFS_STATUS) begin
            next_rdata = status;
        end else begin
            next_rdata = '0;
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            halt  <= 1'b0;
            rdata <= RST_WORD;
        end else begin
            halt  <= next_halt;
            rdata <= next_rdata;
        end
    end

    assign RDATA_O            = rdata;
    assign POS_START_O        = start;
    assign POS_SET_O          = pos;
    assign POS_HALT_O         = halt;
    assign PROGRAM_OUTPUT_A_O = out_lvl[0];
    assign PROGRAM_OUTPUT_B_O = out_lvl[1];

    AST_BRANCH_A: assert property (
        (state == ST_EXEC && cmd == CMD_BRANCH && !hold && !ctrl_wr && eval_a && !eval_b && lat_a
         && mode_a != BM_COMPLETE)
        |=> (state == ST_FETCH && line == $past(branch_input_a)))
        else $error("branch on input a did not go to next line one");
    AST_BRANCH_B: assert property (
        (state == ST_EXEC && cmd == CMD_BRANCH && !hold && !ctrl_wr && eval_b && !eval_a && lat_b
         && mode_b != BM_COMPLETE)
        |=> (state == ST_FETCH && line == $past(branch_input_b)))
        else $error("branch on input b did not go to next line two");
    AST_WAIT: assert property (
        (state == ST_EXEC && cmd == CMD_BRANCH && !ctrl_wr && (eval_a || eval_b) && !lat_a && !lat_b)
        |=> (state == ST_EXEC && $stable(line)))
        else $error("branch line left without an edge");
    AST_AUTO: assert property (
        (state == ST_EXEC && cmd == CMD_BRANCH && !hold && !ctrl_wr && !eval_a && !eval_b)
        |=> (state == ST_FETCH && line == $past(branch_input_a)) ##1 state == ST_EXEC)
        else $error("unevaluated branch did not proceed");
    AST_FIRST: assert property (
        (state == ST_EXEC && cmd == CMD_BRANCH && !hold && !ctrl_wr && go_a && go_b && first_b)
        |=> line == $past(branch_input_b))
        else $error("earlier edge on input b not honoured");
    AST_MOVE: assert property (
        (state == ST_EXEC && cmd == CMD_MOVE && !hold && !ctrl_wr)
        |=> (POS_START_O && POS_SET_O == $past(pos_fld) && state == ST_FETCH) ##1 !POS_START_O)
        else $error("move line did not start a run and advance");
    AST_LEVEL: assert property (
        (state == ST_EXEC && first && cmd == CMD_LEVEL && lvl_imm && !hold && !ctrl_wr)
        |=> line == ($past(in_a) ? $past(branch_input_a) : $past(branch_input_b)))
        else $error("immediate level test chose the wrong line");
    AST_LEVEL_WAIT: assert property (
        (state == ST_EXEC && cmd == CMD_LEVEL && !lvl_imm && run_active && !tr_rise && !ctrl_wr)
        |=> state == ST_EXEC)
        else $error("level test did not wait for the run");
    AST_STOP: assert property (
        (state == ST_EXEC && hold && running && !ctrl_wr)
        |=> (state == ST_EXEC && $stable(line) && POS_HALT_O))
        else $error("stop did not hold the line");
    AST_IGNORE: assert property (
        (rise_a && mode_a == BM_IGNORE && run_active && !lat_a)
        |=> !lat_a)
        else $error("edge during a run was not ignored");
endmodule // csq_sequencer
`default_nettype wire

// ==== tb/csq_partner.sv ====
// Model of the branch switches, the stop switch and the positioning engine.
`timescale 1ns/1ps
`default_nettype none
module csq_partner (
    // Clock, reset and bench requests
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic [2:0] req_i,
    input  wire logic [7:0] run_len_i,
    // Sequencer side
    input  wire logic       pos_start_i,
    output logic      [2:0] pins_o,
    output logic            reached_o,
    output logic            remain_o
);
    logic [7:0] cnt;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pins_o <= 3'h4;
            reached_o <= 1'b0;
            cnt <= 8'h00;
        end else begin
            pins_o <= req_i;
            if (pos_start_i) begin
                reached_o <= 1'b0;
                cnt <= run_len_i;
            end else if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
                reached_o <= (cnt == 8'h01);
            end
        end
    end
    assign remain_o = (cnt != 8'h00) && (cnt < 8'h04);
endmodule // csq_partner
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the course program sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import csq_pkg::*;
    logic              CLK_I = 1'b0;
    logic              RSTN_I = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] st;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic              start, halt, reached, remain, out_a, out_b;
    logic [POS_W-1:0]  pos_set;
    logic [2:0]        req = 3'h4;
    logic [2:0]        pins;
    int                fails = 0;
    int                comparisons = 0;
    always #50 CLK_I = ~CLK_I;
    csq_partner u_partner (.clk_i(CLK_I), .rstn_i(RSTN_I), .req_i(req), .run_len_i(8'hC8),
        .pos_start_i(start), .pins_o(pins), .reached_o(reached), .remain_o(remain));
    csq_sequencer u_dut (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .BRANCH_INPUT_A_I(pins[0]), .BRANCH_INPUT_B_I(pins[1]),
        .STOP_N_I(pins[2]), .TARGET_REACHED_I(reached), .REMAIN_DIST_I(remain),
        .POS_START_O(start), .POS_SET_O(pos_set), .POS_HALT_O(halt),
        .PROGRAM_OUTPUT_A_O(out_a), .PROGRAM_OUTPUT_B_O(out_b));
    task automatic chk(string name, logic [DATA_W-1:0] got, logic [DATA_W-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge CLK_I);
    endtask
    task automatic wr_reg(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        @(posedge CLK_I);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge CLK_I);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(logic [ADDR_W-1:0] a);
        @(posedge CLK_I);
        addr <= a;
        rd <= 1'b1;
        @(posedge CLK_I);
        rd <= 1'b0;
        @(negedge CLK_I);
        st = rdata;
    endtask
    // Polls status until the masked field matches, then compares it.
    task automatic wait_st(logic [DATA_W-1:0] m, logic [DATA_W-1:0] v);
        repeat (60) begin
            rd_reg(OFS_STATUS);
            if ((st & m) === v) break;
        end
        chk("status", st & m, v);
    endtask
    task automatic set_in(logic [2:0] v, int n);
        @(posedge CLK_I);
        req <= v;
        cyc(n);
    endtask
    function automatic logic [DATA_W-1:0] pw(logic [1:0] c, logic [2:0] ev, logic [1:0] ma,
        logic [1:0] mb, logic lim, logic [1:0] oa, logic [3:0] n1, logic [3:0] n2, logic [5:0] p);
        pw = DATA_W'(c) | (DATA_W'(ev) << EVAL_A_BIT) | (DATA_W'(ma) << MODE_A_LSB)
           | (DATA_W'(mb) << MODE_B_LSB) | (DATA_W'(lim) << LVL_IMM_BIT) | (DATA_W'(oa) << OUT_A_LSB)
           | (DATA_W'(n1) << BRANCH_INPUT_A_LSB) | (DATA_W'(n2) << BRANCH_INPUT_B_LSB) | (DATA_W'(p) << POS_LSB);
    endfunction
    task automatic t_load();
        wr_reg(OFS_PROG + 8'h00, pw(CMD_MOVE, 3'h0, 2'h0, 2'h0, 1'b0, 2'h1, 4'h1, 4'h0, 6'h05));
        wr_reg(OFS_PROG + 8'h04, pw(CMD_BRANCH, 3'h3, 2'h1, 2'h1, 1'b0, 2'h1, 4'h3, 4'h2, 6'h00));
        wr_reg(OFS_PROG + 8'h08, pw(CMD_END, 3'h0, 2'h0, 2'h0, 1'b0, 2'h0, 4'h0, 4'h0, 6'h00));
        wr_reg(OFS_PROG + 8'h0C, pw(CMD_LEVEL, 3'h0, 2'h0, 2'h0, 1'b1, 2'h1, 4'h4, 4'h2, 6'h00));
        wr_reg(OFS_PROG + 8'h10, pw(CMD_BRANCH, 3'h3, 2'h1, 2'h1, 1'b0, 2'h1, 4'h2, 4'h6, 6'h00));
        wr_reg(OFS_PROG + 8'h18, pw(CMD_BRANCH, 3'h0, 2'h0, 2'h0, 1'b0, 2'h1, 4'h7, 4'h2, 6'h00));
        wr_reg(OFS_PROG + 8'h1C, pw(CMD_LEVEL, 3'h0, 2'h0, 2'h0, 1'b1, 2'h1, 4'h8, 4'h8, 6'h00));
        wr_reg(OFS_PROG + 8'h20, pw(CMD_BRANCH, 3'h5, 2'h0, 2'h0, 1'b0, 2'h1, 4'h2, 4'h2, 6'h00));
        wr_reg(OFS_PROG + 8'h24, pw(CMD_LEVEL, 3'h0, 2'h0, 2'h0, 1'b1, 2'h0, 4'h2, 4'h8, 6'h00));
        wr_reg(8'hFC, 32'hFFFF_FFFF);
        rd_reg(8'hFC);
        chk("unmapped", st, 32'h0000_0000);
        rd_reg(OFS_STATUS);
        chk("status reset", st, 32'h0000_0000);
        $display("load and reset done");
    endtask
    task automatic t_run();
        wr_reg(OFS_CTRL, 32'h0000_0001);
        wait_st(32'h0000_00F4, 32'h0000_0014);
        chk("pos", 32'(pos_set), 32'h0000_0005);
        set_in(3'h5, 2);
        wait_st(32'h0000_00F4, 32'h0000_0044);
        chk("flags", st & 32'h0005_3F03, 32'h0005_0501);
        set_in(3'h7, 2);
        wait_st(32'h0000_00F0, 32'h0000_0080);
        $display("branch chain done");
    endtask
    task automatic t_stop();
        set_in(3'h4, 3);
        set_in(3'h5, 8);
        wait_st(32'h0000_00F1, 32'h0000_0081);
        repeat (300) if (reached !== 1'b1) @(posedge CLK_I);
        set_in(3'h1, 4);
        set_in(3'h0, 3);
        set_in(3'h1, 8);
        rd_reg(OFS_STATUS);
        chk("stop", st & 32'h0000_00F3, 32'h0000_0083);
        chk("halt", 32'(halt), 32'h0000_0001);
        set_in(3'h5, 2);
        wait_st(32'h0000_0001, 32'h0000_0000);
        $display("ignore and stop done");
    endtask
    task automatic t_low();
        set_in(3'h4, 4);
        wr_reg(OFS_CTRL, 32'h0000_0091);
        wait_st(32'h0000_00F1, 32'h0000_0081);
        wr_reg(OFS_CTRL, 32'h0000_0002);
        wait_st(32'h0000_0001, 32'h0000_0000);
        $display("level low done");
    endtask
    // Complete-first on both inputs: input b rises before input a during the run.
    task automatic t_first();
        wr_reg(OFS_PROG + 8'h28, pw(CMD_MOVE, 3'h0, 2'h0, 2'h0, 1'b0, 2'h2, 4'hB, 4'h0, 6'h09) | 32'h0000_3000);
        wr_reg(OFS_PROG + 8'h2C, pw(CMD_BRANCH, 3'h3, 2'h2, 2'h2, 1'b0, 2'h2, 4'h2, 4'h8, 6'h00) | 32'h0000_3000);
        wr_reg(OFS_CTRL, 32'h0000_00A1);
        set_in(3'h6, 4);
        set_in(3'h7, 4);
        rd_reg(OFS_STATUS);
        chk("complete wait", st & 32'h000C_00F4, 32'h0000_00B4);
        repeat (300) if (reached !== 1'b1) @(posedge CLK_I);
        wait_st(32'h0000_00F1, 32'h0000_0081);
        wr_reg(OFS_CTRL, 32'h0000_0002);
        rd_reg(OFS_STATUS);
        chk("outputs", st & 32'h000C_0000, 32'h0004_0000);
        chk("output ports", 32'({out_b, out_a}), 32'h0000_0001);
        $display("first edge done");
    endtask
    task automatic finish_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #3_000_000;
        fails++;
        finish_test();
    end
    initial begin
        cyc(12);
        RSTN_I <= 1'b1;
        t_load();
        t_run();
        t_stop();
        t_low();
        t_first();
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
